// file: adc_format_core.sv
// Combinational formatter: raw signed converter sample to 10-bit result code.
// Assumes raw sample already carries the analog scaling of 1024 over the reference.
`timescale 1ns/1ps
`include "adc_result_params.svh"
module adc_format_core #(
    parameter int RAW_W = 16
) (
    input wire logic signed [RAW_W-1:0] raw_i,
    input wire adc_result_pkg::format_t format_i,
    input wire adc_result_pkg::gain_t gain_i,
    output logic [9:0] code_o
);
    initial begin
        if (RAW_W < 12 || RAW_W > 24) begin
            $error("RAW_W out of range");
        end
    end
    // Gained sample, wide enough for 32x on any raw value
    logic signed [RAW_W+5:0] gained;
    logic signed [RAW_W+5:0] halved;
    // Apply the selected differential gain
    always_comb begin
        case (gain_i)
            adc_result_pkg::GAIN_8X: gained = (RAW_W+6)'(raw_i) <<< 3;
            adc_result_pkg::GAIN_20X: gained = (RAW_W+6)'(raw_i) * (RAW_W+6)'(20);
            adc_result_pkg::GAIN_32X: gained = (RAW_W+6)'(raw_i) <<< 5;
            default: gained = (RAW_W+6)'(raw_i);
        endcase
    end
    // Bipolar scale is 512 over reference, half the unipolar one
    assign halved = gained >>> 1;
    // Clamp into the code range of the chosen format
    always_comb begin
        case (format_i)
            adc_result_pkg::FMT_BIPOLAR: begin
                if (halved > (RAW_W+6)'($signed(11'sh1FF))) begin
                    code_o = `BIP_MAX;
                end else if (halved < -(RAW_W+6)'(512)) begin
                    code_o = `BIP_MIN;
                end else begin
                    code_o = halved[9:0];
                end
            end
            adc_result_pkg::FMT_UNIPOLAR: begin
                if (gained < 0) begin
                    code_o = 10'h000;
                end else if (gained > (RAW_W+6)'(1023)) begin
                    code_o = `CODE_MAX;
                end else begin
                    code_o = gained[9:0];
                end
            end
            default: begin
                // Gain never applies to single-ended inputs
                if (raw_i < 0) begin
                    code_o = 10'h000;
                end else if (raw_i > RAW_W'(1023)) begin
                    code_o = `CODE_MAX;
                end else begin
                    code_o = raw_i[9:0];
                end
            end
        endcase
    end
endmodule

// file: adc_result_format_temp_cal.sv
// Result presentation, channel select, calibration byte read-out.
// Assumes a converter front end strobes raw samples; software uses Wishbone.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "adc_result_params.svh"
module adc_result_format_temp_cal #(
    parameter int RAW_W = 16,
    parameter bit SMALL_VARIANT = 1'b0,
    parameter logic [7:0] GAIN_CAL = 8'h80, // Arbitrary default calibration
    parameter logic [7:0] OFFSET_CAL = 8'h00 // Arbitrary default calibration
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic conv_done_i,
    input wire logic signed [RAW_W-1:0] raw_i,
    output logic [4:0] channel_select_bits_o,
    output logic temp_sensor_en_o,
    output logic bipolar_mode_o,
    output logic [1:0] gain_sel_o,
    output logic conversion_done_flag_o
);
    // Registers visible to software, plus the internal load window timer
    logic [7:0] channel_mux_reg;
    logic [7:0] converter_ctrl_status_b;
    logic conversion_done_flag;
    logic [9:0] result_code;
    logic [7:0] self_program_ctrl_reg;
    logic [7:0] spm_addr;
    logic [7:0] spm_data;
    logic [1:0] load_timer;
    // Bus decode
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic [9:0] next_code;
    logic [15:0] view;
    logic [7:0] sig_byte;
    adc_result_pkg::format_t fmt;
    adc_result_pkg::gain_t gain;
    logic [4:0] chan;
    logic diff;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_en = bus_req & ~wb_we_i;
    assign chan = channel_mux_reg[4:0];
    // Channels 0x0C to 0x1D, above the single-ended set and the sensor, are differential pairs
    assign diff = (chan > 5'h0A) && (chan < 5'h1E) && (chan != `CHAN_TEMP);

    // Gain from the channel code: listed differential codes 1x, other differential codes 20x, single-ended 1x
    always_comb begin
        if (!diff) begin
            gain = adc_result_pkg::GAIN_1X;
        end else if (chan == 5'h0C || chan == 5'h0F || chan == 5'h10 || chan == 5'h13 ||
                     chan == 5'h15 || chan == 5'h18 || chan == 5'h1A || chan == 5'h1D) begin
            gain = adc_result_pkg::GAIN_1X;
        end else begin
            gain = adc_result_pkg::GAIN_20X;
        end
    end

    // Format follows channel kind and the bipolar bit
    always_comb begin
        if (!diff) begin
            fmt = adc_result_pkg::FMT_SINGLE;
        end else if (converter_ctrl_status_b[`BIT_BIPOLAR]) begin
            fmt = adc_result_pkg::FMT_BIPOLAR;
        end else begin
            fmt = adc_result_pkg::FMT_UNIPOLAR;
        end
    end

    adc_format_core #(
        .RAW_W(RAW_W)
    ) u_core (
        .raw_i(raw_i),
        .format_i(fmt),
        .gain_i(gain),
        .code_o(next_code)
    );

    // Capture result and raise done flag together; held until next strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_code <= 10'h000;
        end else if (conv_done_i) begin
            result_code <= next_code;
        end
    end

    // Done flag: set wins over a software clear by writing one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_done_flag <= 1'b0;
        end else if (conv_done_i) begin
            conversion_done_flag <= 1'b1;
        end else if (wr_en && wb_adr_i == `OFS_STATUS && wb_dat_i[`BIT_DONE]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // Alignment view applies at once, even mid-conversion
    always_comb begin
        if (channel_mux_reg[`BIT_LEFT_ADJUST]) begin
            view = {result_code, 6'h00};
        end else begin
            view = {6'h00, result_code};
        end
    end

    // Channel and control writes; all reset to zero so unipolar is default
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_mux_reg <= 8'h00;
            converter_ctrl_status_b <= 8'h00;
            spm_addr <= 8'h00;
        end else if (wr_en) begin
            case (wb_adr_i)
                `OFS_MUX: channel_mux_reg <= wb_dat_i[7:0];
                `OFS_CTRL_B: converter_ctrl_status_b <= wb_dat_i[7:0];
                `OFS_SPM_ADDR: spm_addr <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Signature row lookup of the calibration bytes
    always_comb begin
        sig_byte = 8'h00;
        if (SMALL_VARIANT) begin
            if (spm_addr[4:0] == `SIG_OFFSET_SMALL) sig_byte = OFFSET_CAL;
            if (spm_addr[4:0] == `SIG_GAIN_SMALL) sig_byte = GAIN_CAL;
        end else begin
            if (spm_addr[4:0] == `SIG_OFFSET_BIG) sig_byte = OFFSET_CAL;
            if (spm_addr[4:0] == `SIG_GAIN_BIG) sig_byte = GAIN_CAL;
        end
    end

    // Signature read: enable bits open a short load window, then self-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            self_program_ctrl_reg <= 8'h00;
            load_timer <= 2'd0;
            spm_data <= 8'h00;
        end else if (wr_en && wb_adr_i == `OFS_SPM_CTRL &&
                     !self_program_ctrl_reg[`BIT_SPM_ENABLE]) begin
            self_program_ctrl_reg <= wb_dat_i[7:0];
            load_timer <= 2'(`LOAD_WINDOW_CYCLES);
        end else if (rd_en && wb_adr_i == `OFS_SPM_DATA && load_timer != 2'd0 &&
                     self_program_ctrl_reg[`BIT_SIG_READ]) begin
            spm_data <= sig_byte;
            self_program_ctrl_reg <= 8'h00;
            load_timer <= 2'd0;
        end else if (load_timer != 2'd0) begin
            load_timer <= load_timer - 2'd1;
            if (load_timer == 2'd1) begin
                self_program_ctrl_reg <= 8'h00; // Window missed, abandon
            end
        end
    end

    // Wishbone answer: one cycle after request, zero for unmapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_en) begin
                case (wb_adr_i)
                    `OFS_MUX: wb_dat_o <= {24'h000000, channel_mux_reg};
                    `OFS_CTRL_B: wb_dat_o <= {24'h000000, converter_ctrl_status_b};
                    `OFS_STATUS: wb_dat_o <= {31'h0, conversion_done_flag};
                    `OFS_RESULT_LOW: wb_dat_o <= {24'h000000, view[7:0]};
                    `OFS_RESULT_HIGH: wb_dat_o <= {24'h000000, view[15:8]};
                    `OFS_SPM_CTRL: wb_dat_o <= {24'h000000, self_program_ctrl_reg};
                    `OFS_SPM_DATA: wb_dat_o <= {24'h000000,
                        (load_timer != 2'd0 && self_program_ctrl_reg[`BIT_SIG_READ]) ?
                        sig_byte : spm_data};
                    `OFS_SPM_ADDR: wb_dat_o <= {24'h000000, spm_addr};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs toward the analog side, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_select_bits_o <= 5'h00;
            temp_sensor_en_o <= 1'b0;
            bipolar_mode_o <= 1'b0;
            gain_sel_o <= 2'b00;
            conversion_done_flag_o <= 1'b0;
        end else begin
            channel_select_bits_o <= chan;
            temp_sensor_en_o <= (chan == `CHAN_TEMP);
            bipolar_mode_o <= converter_ctrl_status_b[`BIT_BIPOLAR];
            gain_sel_o <= gain;
            conversion_done_flag_o <= conversion_done_flag;
        end
    end

    // Result changes only on a completion strobe
    result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(conv_done_i) |-> $stable(result_code)) else $error("result moved");
    done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done_i |=> conversion_done_flag) else $error("done not set");
    sensor_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan == `CHAN_TEMP) |=> temp_sensor_en_o) else $error("sensor off");
    unipolar_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done_i && fmt == adc_result_pkg::FMT_UNIPOLAR && raw_i < 0
        |=> result_code == 10'h000) else $error("no zero clamp");
    single_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done_i && fmt == adc_result_pkg::FMT_SINGLE && raw_i > RAW_W'(1023)
        |=> result_code == `CODE_MAX) else $error("no top clamp");
    bipolar_sign_a: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_done_i && fmt == adc_result_pkg::FMT_BIPOLAR && raw_i < 0
        |=> result_code[9]) else $error("sign wrong");
    left_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
        channel_mux_reg[`BIT_LEFT_ADJUST] |-> view[5:0] == 6'h00 &&
        view[15:6] == result_code) else $error("left view wrong");
    load_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(self_program_ctrl_reg[`BIT_SPM_ENABLE]) |-> ##[1:3]
        !self_program_ctrl_reg[`BIT_SPM_ENABLE]) else $error("window stuck");
    default_uni_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> !converter_ctrl_status_b[`BIT_BIPOLAR]) else $error("not unipolar");
endmodule

// file: adc_result_params.svh
// Constants for the converter result presentation block.
// Assumes a 25 MHz system clock and a classic Wishbone slave port, 32-bit data.
// Summary of operation
// - Result readable only after done flag; result reads are not gated by the flag
// - Single-ended code is straight binary
// - Single-ended range 0x000 to 0x3FF, clamped
// - Unipolar differential, negative saturates to zero
// - Two gains, 1x and 20x, picked by channel code
// - Unipolar default, bipolar by software bit
// - Bipolar two's complement 0x200 to 0x1FF
// - Top result bit is the sign in bipolar
// - Gain unsigned 1/128, offset signed
// - Calibration bytes at variant addresses
// - Left-adjust changes result view immediately
// - Channel eleven selects temperature sensor
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH
`define OFS_MUX 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_RESULT_HIGH 8'h10
`define OFS_SPM_CTRL 8'h14
`define OFS_SPM_DATA 8'h18
`define OFS_SPM_ADDR 8'h1C
`define BIT_LEFT_ADJUST 5
`define BIT_BIPOLAR 4
`define BIT_DONE 0
`define BIT_SPM_ENABLE 0
`define BIT_SIG_READ 5
`define CHAN_TEMP 5'h0B
`define SIG_OFFSET_BIG 5'h05
`define SIG_GAIN_BIG 5'h07
`define SIG_OFFSET_SMALL 5'h1F
`define SIG_GAIN_SMALL 5'h1E
`define LOAD_WINDOW_CYCLES 3
`define CODE_MAX 10'h3FF
`define BIP_MAX 10'h1FF
`define BIP_MIN 10'h200
`endif

// file: adc_result_pkg.sv
// Types shared by the converter result presentation block.
// Assumes the constants header is included by the modules that need numbers.
package adc_result_pkg;
    typedef enum logic [1:0] {
        GAIN_1X,
        GAIN_8X,
        GAIN_20X,
        GAIN_32X
    } gain_t;
    typedef enum logic [1:0] {
        FMT_SINGLE,
        FMT_UNIPOLAR,
        FMT_BIPOLAR
    } format_t;
endpackage

// file: conv_front_model.sv
// Converter front end model: one sample per request, after a conversion time.
// Assumes requests are spaced by more than LAT clocks.
`timescale 1ns/1ps
module conv_front_model #(
    parameter int LAT = 13 // Conversion length in clocks
) (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic signed [15:0] value_i,
    output logic done_o,
    output logic signed [15:0] raw_o
);
    int cnt = 0; // Clocks left in the running conversion
    logic signed [15:0] held = 16'sh0000; // Sample taken at request
    initial done_o = 1'b0;
    initial raw_o = 16'sh0000;
    // Sample is valid only with the done pulse; junk that flips otherwise
    always @(posedge clk_i) begin
        done_o <= (cnt == 1);
        raw_o <= (cnt == 1) ? held : ~raw_o;
        if (go_i) begin
            held <= value_i;
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: tb.sv
// Self-checking bench for the result presentation block.
// Assumes the front end model file and the design files are compiled first.
`timescale 1ns/1ps
`include "adc_result_params.svh"
module tb;
    localparam logic [7:0] GCAL = 8'h9C; // Calibration gain seen by software
    localparam logic [7:0] OCAL = 8'hF4; // Negative offset byte
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0; // Drives both cycle and strobe
    logic we = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic ack_q = 1'b0; // Acknowledge as it stood through the last cycle, free of edge races
    logic go = 1'b0; // Conversion request to the model
    logic signed [15:0] value = 16'sh0000;
    logic done;
    logic signed [15:0] raw;
    logic [4:0] chan;
    logic tsen;
    logic bip;
    logic [1:0] gsel;
    logic flag;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int chs[3] = '{3, 12, 14}; // Single, differential 1x, differential 20x
    int gs[3] = '{1, 1, 20};
    logic [31:0] seed = 32'h00000003;
    logic [31:0] rd;
    logic [31:0] lo;
    adc_result_format_temp_cal #(.RAW_W(16), .SMALL_VARIANT(1'b0), .GAIN_CAL(GCAL),
        .OFFSET_CAL(OCAL)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .conv_done_i(done), .raw_i(raw),
        .channel_select_bits_o(chan), .temp_sensor_en_o(tsen), .bipolar_mode_o(bip),
        .gain_sel_o(gsel), .conversion_done_flag_o(flag));
    conv_front_model #(.LAT(13)) front_u (.clk_i(clk_i), .go_i(go), .value_i(value),
        .done_o(done), .raw_o(raw));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // Mid-cycle copy so the master sees the settled acknowledge at the next rising edge
    always @(negedge clk_i) begin
        ack_q = ack;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single cycle; holds everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_q !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            num_errors++;
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Reference code: gain applied, halved in bipolar, clamped to the format range
    function automatic logic [9:0] model(input int r, input int g, input bit b);
        int v;
        v = r * g;
        if (b) begin
            v = v / 2;
            v = v > 511 ? 511 : (v < -512 ? -512 : v);
        end else begin
            v = v > 1023 ? 1023 : (v < 0 ? 0 : v);
        end
        return v[9:0];
    endfunction
    task automatic convert(input int r);
        int n;
        n = 0;
        @(posedge clk_i);
        go <= 1'b1;
        value <= 16'(r);
        @(posedge clk_i);
        go <= 1'b0;
        while (flag !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
        end
    endtask
    initial begin
        int r;
        int k;
        bit b;
        bit d;
        logic [9:0] c;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({27'h0, tsen, bip, gsel, flag}, 32'h0);
        for (int a = 0; a <= 16; a += 4) begin
            wb(1'b0, 8'(a), 32'h0, rd);
            chk(rd, 32'h0);
        end
        wb(1'b0, 8'hF0, 32'h0, rd);
        chk(rd, 32'h0);
        for (int i = 0; i < 24; i++) begin
            k = i % 3;
            b = (i / 3) % 2;
            d = chs[k] >= 11;
            wb(1'b1, `OFS_CTRL_B, 32'(b) << `BIT_BIPOLAR, rd);
            wb(1'b1, `OFS_MUX, 32'(chs[k]), rd);
            seed = xs(seed);
            r = (int'(seed % 32'd1800) - 900) & ~1;
            convert(r);
            wb(1'b0, `OFS_STATUS, 32'h0, rd);
            chk(rd[0], 1'b1);
            chk(bip, b);
            if (d) begin
                chk(gsel, gs[k] == 20 ? 2'h2 : 2'h0);
            end
            c = model(r, d ? gs[k] : 1, b && d);
            repeat (3) @(posedge clk_i);
            wb(1'b0, `OFS_RESULT_LOW, 32'h0, lo);
            wb(1'b0, `OFS_RESULT_HIGH, 32'h0, rd);
            chk({rd[15:0], lo[7:0]}, {14'h0, c});
            if (b && d) begin
                chk(rd[1], r < 0);
            end
            wb(1'b1, `OFS_MUX, 32'(chs[k]) | 32'h20, rd);
            wb(1'b0, `OFS_RESULT_LOW, 32'h0, lo);
            wb(1'b0, `OFS_RESULT_HIGH, 32'h0, rd);
            chk({rd[7:0], lo[7:0]}, {c, 6'h00});
            wb(1'b1, `OFS_STATUS, 32'h1, rd);
            wb(1'b0, `OFS_STATUS, 32'h0, rd);
            chk(rd[0], 1'b0);
        end
        wb(1'b1, `OFS_MUX, 32'(`CHAN_TEMP), rd);
        @(posedge clk_i);
        chk({tsen, chan}, {1'b1, `CHAN_TEMP});
        sel <= 4'hE;
        wb(1'b1, `OFS_MUX, 32'h3, rd);
        sel <= 4'hF;
        chk(chan, `CHAN_TEMP);
        wb(1'b1, `OFS_SPM_ADDR, 32'(`SIG_OFFSET_BIG), rd);
        wb(1'b1, `OFS_SPM_CTRL, 32'h21, rd);
        wb(1'b0, `OFS_SPM_DATA, 32'h0, rd);
        chk(rd, {24'h0, OCAL});
        wb(1'b0, `OFS_SPM_CTRL, 32'h0, rd);
        chk(rd[0], 1'b0);
        wb(1'b1, `OFS_SPM_ADDR, 32'(`SIG_GAIN_BIG), rd);
        wb(1'b1, `OFS_SPM_CTRL, 32'h21, rd);
        wb(1'b0, `OFS_SPM_DATA, 32'h0, rd);
        chk(rd, {24'h0, GCAL});
        wb(1'b1, `OFS_SPM_CTRL, 32'h21, rd);
        repeat (6) @(posedge clk_i);
        wb(1'b0, `OFS_SPM_CTRL, 32'h0, rd);
        chk(rd[0], 1'b0);
        close_out();
    end
endmodule
